// ==== rtl/data_move_instr_decode.sv ====
// decode and execute of the data-move instructions of an 8-bit core
// assumes a synchronous data-space ram on MCLK: read data one clock
// after DS_RD, write taken at the edge that ends DS_WR
//
// What this block does
// - copy_file_reg moves a register to W (d=0) or back to itself (d=1), setting N and Z.
// - copy_file_reg and store_work_reg address a 256-byte bank, access bank when a=0, bank_select_reg when a=1.
// - copy_reg_to_reg takes full 12-bit source and destination over 000h-FFFh and changes no flag.
// - copy_reg_to_reg is two program words and takes two instruction cycles, plus the idle cycles in between if the second word comes late.
// - copy_reg_to_reg treats W as an ordinary data-space location for source or destination.
// - load_bank_literal writes its 8-bit literal to bank_select_reg in one cycle, no flags.
// - load_work_literal puts its literal into W, no flags.
// - store_work_reg writes W into the addressed register with banked addressing, no flags.
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "dmove_params.svh"

module data_move_instr_decode
    import dmove_pkg::*;
#(
    parameter logic [11:0] WORK_ADDR = `DM_WORK_ADDR,
    parameter logic [7:0]  ACC_SPLIT = `DM_ACC_SPLIT
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    // wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // data space
    output logic      [11:0] DS_ADDR,
    output logic             DS_RD,
    output logic             DS_WR,
    output logic      [7:0]  DS_WDATA,
    input  wire logic [7:0]  DS_RDATA
);

    phase_e      state_reg;
    op_e         op_reg;
    op_e         op_next;
    logic [15:0] instr_reg;
    logic [7:0]  work_reg;
    logic [7:0]  bank_reg;
    logic [7:0]  data_reg;
    logic [7:0]  proc_val;
    logic [11:0] addr_reg;
    logic [11:0] addr_next;
    logic        neg_reg;
    logic        zero_reg;
    logic        pend_reg;
    logic        unk_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        idle;
    logic        wb_req;
    logic        wb_wr;
    logic        issue;
    logic        is_work;
    logic        needs_read;
    logic        writes_ds;

    // single-word banked address; the access bank splits low/high
    function automatic logic [11:0] bank_addr(
        input logic [7:0] f,
        input logic       a,
        input logic [7:0] bank_select_reg
    );
        logic [3:0] bank;
        bank = bank_select_reg[3:0];
        if (!a) begin
            bank = (f < ACC_SPLIT) ? 4'h0 : `DM_ACC_HIGH;
        end
        return {bank, f};
    endfunction

    // second word pending means the word can only be a destination
    function automatic op_e decode(
        input logic [15:0] w,
        input logic        pend
    );
        op_e op;
        op = OP_NONE;
        if (pend) begin
            if (w[15:12] == `DM_PAT_DST) begin
                op = OP_COPY_DST;
            end
        end else if (w[15:10] == `DM_PAT_FILE) begin
            op = OP_COPY_FILE;
        end else if (w[15:12] == `DM_PAT_SRC) begin
            op = OP_COPY_SRC;
        end else if (w[15:8] == `DM_PAT_BANK) begin
            op = OP_LOAD_BANK;
        end else if (w[15:8] == `DM_PAT_WORK) begin
            op = OP_LOAD_WORK;
        end else if (w[15:9] == `DM_PAT_STORE) begin
            op = OP_STORE;
        end
        return op;
    endfunction

    assign idle   = (state_reg == ST_IDLE);
    // writes stall until the core is idle so W and bank never race
    assign wb_req = CYC_I && STB_I && !ack_reg && (!WE_I || idle);
    assign wb_wr  = CYC_I && STB_I && ack_reg && WE_I;
    assign issue  = wb_wr && (ADR_I == `DM_OFF_INSTR) && SEL_I[0]
                    && SEL_I[1];
    assign ACK_O  = ack_reg;
    assign DAT_O  = dat_reg;

    assign op_next = decode(instr_reg, pend_reg);

    always_comb begin
        addr_next = `DM_RST_ADDR;
        case (op_next)
            OP_COPY_SRC, OP_COPY_DST: begin
                addr_next = instr_reg[11:0];
            end
            OP_COPY_FILE, OP_STORE: begin
                addr_next = bank_addr(instr_reg[7:0], instr_reg[8],
                                      bank_reg);
            end
            default: begin
                addr_next = `DM_RST_ADDR;
            end
        endcase
    end

    assign is_work    = (addr_reg == WORK_ADDR);
    assign needs_read = (op_next == OP_COPY_FILE)
                        || (op_next == OP_COPY_SRC);
    assign writes_ds  = !is_work && ((op_reg == OP_STORE)
                        || (op_reg == OP_COPY_DST)
                        || (op_reg == OP_COPY_FILE && instr_reg[9]));

    // value formed in phase three
    always_comb begin
        case (op_reg)
            OP_COPY_FILE, OP_COPY_SRC: begin
                proc_val = is_work ? work_reg : DS_RDATA;
            end
            OP_LOAD_BANK, OP_LOAD_WORK: begin
                proc_val = instr_reg[7:0];
            end
            OP_STORE: begin
                proc_val = work_reg;
            end
            default: begin
                proc_val = data_reg;
            end
        endcase
    end

    // one state per phase, one clock per phase
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE:    state_reg <= issue ? ST_DECODE : ST_IDLE;
                ST_DECODE:  state_reg <= ST_READ;
                ST_READ:    state_reg <= ST_PROCESS;
                ST_PROCESS: state_reg <= ST_WRITE;
                ST_WRITE:   state_reg <= ST_IDLE;
                default:    state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            instr_reg <= `DM_RST_WORD;
        end else if (issue) begin
            instr_reg <= DAT_I[15:0];
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            op_reg   <= OP_NONE;
            addr_reg <= `DM_RST_ADDR;
        end else if (state_reg == ST_DECODE) begin
            op_reg   <= op_next;
            addr_reg <= addr_next;
        end
    end

    // data-space strobes: read only in phase two, write only in four
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DS_ADDR  <= `DM_RST_ADDR;
            DS_RD    <= 1'b0;
            DS_WR    <= 1'b0;
            DS_WDATA <= `DM_RST_BYTE;
        end else begin
            DS_RD <= 1'b0;
            DS_WR <= 1'b0;
            if (state_reg == ST_DECODE) begin
                DS_ADDR <= addr_next;
                // W is read in the core, not from ram
                DS_RD   <= needs_read && (addr_next != WORK_ADDR);
            end
            if (state_reg == ST_PROCESS) begin
                // no dummy read for the destination word
                DS_WR    <= writes_ds;
                DS_WDATA <= proc_val;
            end
        end
    end

    // source byte is held across both copy cycles
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            data_reg <= `DM_RST_BYTE;
        end else if (state_reg == ST_PROCESS) begin
            data_reg <= proc_val;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            work_reg <= `DM_RST_BYTE;
        end else if (state_reg == ST_WRITE) begin
            if (op_reg == OP_COPY_FILE && !instr_reg[9]) begin
                work_reg <= data_reg;
            end else if (op_reg == OP_LOAD_WORK) begin
                work_reg <= data_reg;
            end else if (op_reg == OP_COPY_DST && is_work) begin
                work_reg <= data_reg;
            end
        end else if (wb_wr && ADR_I == `DM_OFF_WORK && SEL_I[0]) begin
            work_reg <= DAT_I[7:0];
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bank_reg <= `DM_RST_BYTE;
        end else if (state_reg == ST_WRITE && op_reg == OP_LOAD_BANK) begin
            bank_reg <= data_reg;
        end else if (wb_wr && ADR_I == `DM_OFF_BANK && SEL_I[0]) begin
            bank_reg <= DAT_I[7:0];
        end
    end

    // only the file copy touches flags; all other moves leave them
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            neg_reg  <= 1'b0;
            zero_reg <= 1'b0;
        end else if (state_reg == ST_WRITE && op_reg == OP_COPY_FILE) begin
            neg_reg  <= data_reg[7];
            zero_reg <= (data_reg == `DM_RST_BYTE);
        end
    end

    // waiting for the second copy word; idle cycles in between are
    // the slow case of the copy
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_reg <= 1'b0;
        end else if (state_reg == ST_WRITE) begin
            pend_reg <= (op_reg == OP_COPY_SRC);
        end
    end

    // unknown word: sticky, write one to clear, a new set wins
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            unk_reg <= 1'b0;
        end else if (state_reg == ST_DECODE && op_next == OP_NONE) begin
            unk_reg <= 1'b1;
        end else if (wb_wr && ADR_I == `DM_OFF_STATUS && SEL_I[0]
                     && DAT_I[`DM_ST_UNK]) begin
            unk_reg <= 1'b0;
        end
    end

    // one wait state on every read and on writes while idle; read data captured with ack
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req;
            if (wb_req) begin
                dat_reg <= 32'h0000_0000;
                case (ADR_I)
                    `DM_OFF_INSTR:  dat_reg[15:0] <= instr_reg;
                    `DM_OFF_WORK:   dat_reg[7:0]  <= work_reg;
                    `DM_OFF_BANK:   dat_reg[7:0]  <= bank_reg;
                    `DM_OFF_STATUS: begin
                        dat_reg[`DM_ST_NEG]  <= neg_reg;
                        dat_reg[`DM_ST_ZERO] <= zero_reg;
                        dat_reg[`DM_ST_BUSY] <= !idle;
                        dat_reg[`DM_ST_PEND] <= pend_reg;
                        dat_reg[`DM_ST_UNK]  <= unk_reg;
                    end
                    default:        dat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ==== rtl/dmove_params.svh ====
// offsets, field positions, reset values and opcode patterns of the mover
// assumes a 32-bit classic wishbone bus with byte addresses
`ifndef DMOVE_PARAMS_SVH
`define DMOVE_PARAMS_SVH
`define DM_OFF_INSTR   8'h00
`define DM_OFF_WORK    8'h04
`define DM_OFF_BANK    8'h08
`define DM_OFF_STATUS  8'h0C
`define DM_ST_NEG      0
`define DM_ST_ZERO     1
`define DM_ST_BUSY     2
`define DM_ST_PEND     3
`define DM_ST_UNK      4
`define DM_RST_BYTE    8'h00
`define DM_RST_WORD    16'h0000
`define DM_RST_ADDR    12'h000
`define DM_PAT_FILE    6'h14
`define DM_PAT_SRC     4'hC
`define DM_PAT_DST     4'hF
`define DM_PAT_BANK    8'h01
`define DM_PAT_WORK    8'h0E
`define DM_PAT_STORE   7'h37
`define DM_WORK_ADDR   12'hFE0
`define DM_ACC_SPLIT   8'h80
`define DM_ACC_HIGH    4'hF
`endif

// ==== rtl/dmove_pkg.sv ====
// types shared by the data-move decoder
// assumes nothing beyond a systemverilog compiler
package dmove_pkg;
    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_DECODE  = 5'h02,
        ST_READ    = 5'h04,
        ST_PROCESS = 5'h08,
        ST_WRITE   = 5'h10
    } phase_e;
    typedef enum logic [2:0] {
        OP_NONE      = 3'h0,
        OP_COPY_FILE = 3'h1,
        OP_COPY_SRC  = 3'h2,
        OP_COPY_DST  = 3'h3,
        OP_LOAD_BANK = 3'h4,
        OP_LOAD_WORK = 3'h5,
        OP_STORE     = 3'h6
    } op_e;
endpackage

// ==== tb/data_move_instr_decode_properties.sv ====
// assertions on the data-move decoder ports
// assumes one clock domain, bound to every decoder instance
`timescale 1ns/10ps
module data_move_instr_decode_properties (
    // clock and reset
    input wire logic        MCLK,
    input wire logic        ARST_N,
    // wishbone side
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic        ACK_O,
    // data space
    input wire logic [11:0] DS_ADDR,
    input wire logic        DS_RD,
    input wire logic        DS_WR
);
    // saturating count so stale words never look freshly issued
    logic [3:0]  since_reg;
    logic [15:0] word_reg;
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            since_reg <= 4'hF;
            word_reg  <= 16'h0000;
        end else if (ACK_O && WE_I && ADR_I == 8'h00) begin
            since_reg <= 4'h0;
            word_reg  <= DAT_I[15:0];
        end else if (since_reg != 4'hF) begin
            since_reg <= since_reg + 4'h1;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    a_ack_single: assert property (ACK_O |=> !ACK_O)
        else $error("ack held past one cycle");
    a_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without a request");
    a_read_answer: assert property (CYC_I && STB_I && !WE_I && !ACK_O |=> ACK_O)
        else $error("read not answered next cycle");
    a_read_phase: assert property (DS_RD |-> since_reg == 4'h1)
        else $error("data read outside phase two");
    a_write_phase: assert property (DS_WR |-> since_reg == 4'h3)
        else $error("data write outside phase four");
    a_no_dummy_read: assert property (DS_RD |-> word_reg[15:12] != 4'hF)
        else $error("read during copy second word");
    a_copy_first: assert property (DS_WR |-> word_reg[15:12] != 4'hC)
        else $error("write during copy first word");
    a_literal_quiet: assert property
        (DS_WR |-> !(word_reg[15:8] inside {8'h01, 8'h0E}))
        else $error("literal load wrote data space");
    a_copy_source: assert property (DS_RD && word_reg[15:12] == 4'hC
        |-> DS_ADDR == word_reg[11:0])
        else $error("copy source address wrong");
    a_copy_dest: assert property (DS_WR && word_reg[15:12] == 4'hF
        |-> DS_ADDR == word_reg[11:0])
        else $error("copy destination address wrong");
    c_copy_write: cover property (DS_WR && word_reg[15:12] == 4'hF);
    c_file_read: cover property (DS_RD && word_reg[15:12] == 4'h5);
    c_reg_read: cover property (ACK_O && !WE_I);
endmodule
bind data_move_instr_decode data_move_instr_decode_properties u_props (
    .MCLK(MCLK), .ARST_N(ARST_N), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .DAT_I(DAT_I), .ACK_O(ACK_O),
    .DS_ADDR(DS_ADDR), .DS_RD(DS_RD), .DS_WR(DS_WR));

// ==== tb/test_data_move_instr_decode.sv ====
// self-checking bench for the data-move decoder
// assumes the bench is wishbone master and data-space ram
`timescale 1ns/10ps
module test_data_move_instr_decode;
    logic        MCLK, ARST_N, CYC_I, STB_I, WE_I, ACK_O, DS_RD, DS_WR;
    logic [3:0]  SEL_I;
    logic [7:0]  ADR_I, DS_WDATA, DS_RDATA;
    logic [11:0] DS_ADDR;
    logic [31:0] DAT_I, DAT_O, rdat;
    logic [7:0]  mem [4096];
    int          fails, n_checks;
    logic [15:0] st_w [3] = '{16'h6F77, 16'h6E7F, 16'h6E80};
    logic [11:0] st_a [3] = '{12'h577, 12'h07F, 12'hF80};
    logic [15:0] cp_s [3] = '{16'hC100, 16'hCFFF, 16'hCFE0};
    logic [15:0] cp_d [3] = '{16'hF200, 16'hF000, 16'hF300};
    logic [7:0]  cp_e [3] = '{8'h3C, 8'hA5, 8'h77};

    data_move_instr_decode u_data_move_instr_decode (
        .MCLK(MCLK), .ARST_N(ARST_N), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
        .DAT_O(DAT_O), .ACK_O(ACK_O), .DS_ADDR(DS_ADDR), .DS_RD(DS_RD),
        .DS_WR(DS_WR), .DS_WDATA(DS_WDATA), .DS_RDATA(DS_RDATA));

    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    // unread cycles show the inverse so stale data never passes
    always @(posedge MCLK) begin
        DS_RDATA <= DS_RD ? mem[DS_ADDR] : ~DS_RDATA;
        if (DS_WR) mem[DS_ADDR] <= DS_WDATA;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge MCLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I  <= w;
        ADR_I <= a;
        DAT_I <= d;
        SEL_I <= s;
        do @(posedge MCLK); while (ACK_O !== 1'b1 && ++n < 40);
        rdat = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        chk("ack", 32'h1, {31'h0, ACK_O});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    // issue one word, then poll busy so the next word is never stalled
    task automatic run(input logic [15:0] op);
        int n;
        n = 0;
        wb(1'b1, 8'h00, {16'h0, op});
        do wb(1'b0, 8'h0C, 32'h0); while (rdat[2] !== 1'b0 && ++n < 20);
        // a core that never goes idle counts as a mismatch
        chk("idle", 32'h0, {31'h0, rdat[2]});
    endtask
    task automatic stop_test;
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge MCLK);
        fails++;
        stop_test();
    end
    initial begin
        fails = 0;
        n_checks = 0;
        {ARST_N, CYC_I, STB_I, WE_I, ADR_I, DAT_I} = '0;
        SEL_I = 4'hF;
        DS_RDATA = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
        mem[12'h534] = 8'h80;
        mem[12'h100] = 8'h3C;
        mem[12'hFFF] = 8'hA5;
        repeat (6) @(posedge MCLK);
        ARST_N <= 1'b1;
        rd(8'h0C, 32'h0, "status reset");
        run(16'h0E5A);
        rd(8'h04, 32'h5A, "work");
        rd(8'h0C, 32'h0, "flags");
        run(16'h0105);
        rd(8'h08, 32'h05, "bank");
        foreach (st_w[i]) begin
            run(st_w[i]);
            chk("store", 32'h5A, {24'h0, mem[st_a[i]]});
        end
        rd(8'h0C, 32'h0, "flags");
        run(16'h5134);
        rd(8'h04, 32'h80, "work");
        rd(8'h0C, 32'h1, "flags");
        run(16'h5020);
        rd(8'h0C, 32'h2, "flags");
        run(16'h5334);
        rd(8'h04, 32'h0, "work");
        chk("file", 32'h80, {24'h0, mem[12'h534]});
        run(16'h0E77);
        // destinations stay clear of program counter and stack
        foreach (cp_s[i]) begin
            run(cp_s[i]);
            run(cp_d[i]);
            chk("copy", {24'h0, cp_e[i]}, {24'h0, mem[cp_d[i][11:0]]});
        end
        run(16'hC200);
        run(16'hFFE0);
        rd(8'h04, 32'h3C, "work");
        rd(8'h0C, 32'h1, "flags");
        run(16'hC100);
        rd(8'h0C, 32'h9, "pending");
        repeat (10) @(posedge MCLK);
        run(16'hF201);
        chk("late copy", 32'h3C, {24'h0, mem[12'h201]});
        run(16'hC100);
        run(16'h0E11);
        rd(8'h04, 32'h3C, "work");
        rd(8'h0C, 32'h11, "unknown");
        wb(1'b1, 8'h0C, 32'h10);
        rd(8'h0C, 32'h1, "cleared");
        rd(8'h10, 32'h0, "unmapped");
        // instruction write without both low lanes is not issued
        wb(1'b1, 8'h00, 32'h0E22, 4'h1);
        rd(8'h00, 32'h0E11, "instr lanes");
        rd(8'h04, 32'h3C, "work lanes");
        // reset between runs, with the core idle, brings every register back to zero
        @(posedge MCLK);
        ARST_N <= 1'b0;
        repeat (2) @(posedge MCLK);
        ARST_N <= 1'b1;
        rd(8'h04, 32'h0, "work after reset");
        rd(8'h08, 32'h0, "bank after reset");
        rd(8'h0C, 32'h0, "status after reset");
        run(16'h0E42);
        rd(8'h04, 32'h42, "work after reset");
        stop_test();
    end
endmodule
